//--- inc/ufx_pkg.sv
// Shared constants, states and carriers of the serial transceiver.
package ufx_pkg;

	localparam int unsigned UFX_CORE_MHZ = 100;
	localparam int unsigned UFX_FIFO_DEPTH = 4;
	localparam int unsigned UFX_DATA_W = 8;
	localparam int unsigned UFX_DIV_W = 16;
	localparam int unsigned UFX_FRAC_LSB = 0;
	localparam int unsigned UFX_INT_LSB = 3;
	localparam int unsigned UFX_ACC_W = 17;
	localparam logic [16:0] UFX_TX_STEP = 17'h00008;
	localparam logic [16:0] UFX_RX_STEP = 17'h00010;
	localparam logic [2:0] UFX_LAST_BIT_8 = 3'h7;
	localparam logic [2:0] UFX_LAST_BIT_7 = 3'h6;
	localparam logic [1:0] UFX_SRC_26M = 2'h0;
	localparam logic [1:0] UFX_SRC_13M = 2'h1;
	localparam logic [1:0] UFX_SRC_6M5 = 2'h2;
	localparam logic [1:0] UFX_SRC_3M25 = 2'h3;
	localparam logic [1:0] UFX_PAR_EVEN = 2'h0;
	localparam logic [1:0] UFX_PAR_ODD = 2'h1;
	localparam logic [1:0] UFX_PAR_SPACE = 2'h2;
	localparam logic [1:0] UFX_PAR_MARK = 2'h3;

	typedef struct packed {
		logic [1:0] src_sel;
		logic [15:0] baud_div;
		logic char_length_sel;
		logic par_en;
		logic [1:0] par_mode;
		logic two_stop;
		logic flow_en;
	} ufx_cfg_t;

	typedef struct packed {
		logic missing_stop;
		logic overrun;
		logic parity_err;
	} ufx_err_t;

	typedef enum logic [2:0] {
		UFX_TX_IDLE = 3'h0,
		UFX_TX_START = 3'h1,
		UFX_TX_DATA = 3'h2,
		UFX_TX_PAR = 3'h3,
		UFX_TX_STOP = 3'h4
	} ufx_tx_state_t;

	typedef enum logic [2:0] {
		UFX_RX_IDLE = 3'h0,
		UFX_RX_START = 3'h1,
		UFX_RX_DATA = 3'h2,
		UFX_RX_PAR = 3'h3,
		UFX_RX_STOP = 3'h4
	} ufx_rx_state_t;

endpackage : ufx_pkg

//--- hw/ufx_top.sv
// Serial transceiver with fractional baud generator and transmit/receive queues.
//
// Operation
// - Four selectable sources; line input synchronised
// - Divisor: integer bits 15:3, eighths 2:0
// - Low start bit, then data LSB first
// - Seven or eight data bits, both directions
// - Parity bit after data, before stop
// - One or two high stop bits
// - Next frame at once, else idle high
// - Odd, even, mark, space generated and checked
// - Parity code: even 0, odd 1, space 2, mark 3
// - Transmit and receive queues hold four bytes
// - Data write pushes byte into transmit queue
// - Load shifter only when empty, send frame
// - Transmit empty after full frame, nothing queued
// - Interrupt when flag and its mask set
// - Frame begins on valid start, sampled per bit
// - Second stop bit ignored by receiver
// - First stop queues character, sets not-empty
// - Missing stop flag when stop position low
// - Overrun when character ends, queue full; with flow control, holding stage also full
// - Parity error flag on mismatching parity bit
// - Flow control only while its enable set
// - Queue full: raise ready-to-send, hold frame
// - Start only while clear-to-send low
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Queue
// ****************************************
module ufx_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_b, // Async reset, low
	input wire logic in_valid, // Write request
	output logic in_ready, // Space free
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Entry present
	input wire logic out_ready, // Pop request
	output logic [WIDTH-1:0] out_data // Oldest entry
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	assign in_ready = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_ff[rd_ptr_ff];

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == (AW)'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			end
			if (pop) begin
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ufx_fifo

// ****************************************
// Transceiver
// ****************************************
module ufx_top import ufx_pkg::*; #(
	parameter int unsigned DEPTH = UFX_FIFO_DEPTH
) (
	input wire logic core_clk, // 100 MHz core clock
	input wire logic rst_b, // Async reset, low
	input wire ufx_cfg_t cfg, // Framing, rate, flow setup
	input wire logic tx_wr, // Push byte, one cycle
	input wire logic [7:0] tx_byte, // Byte to send
	output logic tx_not_full, // Transmit queue has room
	output logic tx_empty, // Queue and shifter idle
	input wire logic rx_rd, // Pop byte, one cycle
	output logic [7:0] rx_byte, // Oldest received byte
	output logic rx_not_empty, // Receive queue has data
	output ufx_err_t err_flags, // Sticky receive errors
	input wire ufx_err_t err_clr, // Clear errors, one cycle
	input wire logic [1:0] tx_mask, // {empty, not_full}
	input wire logic [3:0] rx_mask, // {err flags, not_empty}
	output logic irq, // Interrupt, high
	input wire logic rxd, // Serial in
	output logic txd, // Serial out
	input wire logic cts, // Clear to send, low = go
	output logic rts // Ready to send, high = stop
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic par_bit(input logic [7:0] d, input ufx_cfg_t c);
		logic [7:0] m;
		m = c.char_length_sel ? {1'b0, d[6:0]} : d;
		case (c.par_mode)
			UFX_PAR_EVEN: par_bit = ^m;
			UFX_PAR_ODD: par_bit = ~^m;
			UFX_PAR_SPACE: par_bit = 1'b0;
			default: par_bit = 1'b1;
		endcase
	endfunction : par_bit

	// Accumulates eighths of a source tick; carry out marks a period
	function automatic logic [17:0] baud_step(input logic [16:0] acc, input logic [16:0] step,
			input logic [15:0] div);
		logic [16:0] sum;
		sum = acc + step;
		if (sum >= {1'b0, div}) begin
			baud_step = {1'b1, sum - {1'b0, div}};
		end else begin
			baud_step = {1'b0, sum};
		end
	endfunction : baud_step

	// ****************************************
	// Clock source and baud ticks
	// ****************************************
	logic [2:0] presc_ff;
	logic [2:0] src_mask;
	logic src_tick;
	logic [16:0] tx_acc_ff;
	logic [16:0] rx_acc_ff;
	logic [17:0] tx_bs;
	logic [17:0] rx_bs;

	always_comb begin
		case (cfg.src_sel)
			UFX_SRC_26M: src_mask = 3'h0;
			UFX_SRC_13M: src_mask = 3'h1;
			UFX_SRC_6M5: src_mask = 3'h3;
			default: src_mask = 3'h7;
		endcase
	end
	assign src_tick = ((presc_ff & src_mask) == 3'h0);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_ff <= 3'h0;
		end else begin
			presc_ff <= presc_ff + 3'h1;
		end
	end

	assign tx_bs = baud_step(tx_acc_ff, UFX_TX_STEP, cfg.baud_div);
	assign rx_bs = baud_step(rx_acc_ff, UFX_RX_STEP, cfg.baud_div);

	// ****************************************
	// Transmit path
	// ****************************************
	ufx_tx_state_t tx_state_ff;
	logic [7:0] tx_shift_ff;
	logic [2:0] tx_bit_ff;
	logic tx_par_ff;
	logic tx_stop_ff;
	logic txd_ff;
	logic tx_tick;
	logic tx_last_stop;
	logic cts_ok;
	logic tx_load;
	logic txf_valid;
	logic [7:0] txf_data;
	logic [2:0] tx_last_bit;

	ufx_fifo #(.WIDTH(UFX_DATA_W), .DEPTH(DEPTH)) u_txq (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(tx_wr),
		.in_ready(tx_not_full),
		.in_data(tx_byte),
		.out_valid(txf_valid),
		.out_ready(tx_load),
		.out_data(txf_data)
	);

	assign tx_tick = src_tick & tx_bs[17] & (tx_state_ff != UFX_TX_IDLE);
	assign tx_last_stop = ~cfg.two_stop | tx_stop_ff;
	assign cts_ok = ~cfg.flow_en | ~cts;
	assign tx_last_bit = cfg.char_length_sel ? UFX_LAST_BIT_7 : UFX_LAST_BIT_8;
	// Loads only with the shifter free; back-to-back from the last stop bit
	assign tx_load = txf_valid & cts_ok & ((tx_state_ff == UFX_TX_IDLE) |
		((tx_state_ff == UFX_TX_STOP) & tx_tick & tx_last_stop));
	assign tx_empty = ~txf_valid & (tx_state_ff == UFX_TX_IDLE);
	assign txd = txd_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_acc_ff <= 17'h00000;
		end else if (tx_state_ff == UFX_TX_IDLE || tx_load) begin
			tx_acc_ff <= 17'h00000;
		end else if (src_tick) begin
			tx_acc_ff <= tx_bs[16:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_ff <= UFX_TX_IDLE;
			tx_shift_ff <= 8'h00;
			tx_bit_ff <= 3'h0;
			tx_par_ff <= 1'b0;
			tx_stop_ff <= 1'b0;
			txd_ff <= 1'b1;
		end else if (tx_load) begin
			tx_state_ff <= UFX_TX_START;
			tx_shift_ff <= txf_data;
			tx_par_ff <= par_bit(txf_data, cfg);
			txd_ff <= 1'b0;
		end else if (tx_tick) begin
			case (tx_state_ff)
				UFX_TX_START: begin
					tx_state_ff <= UFX_TX_DATA;
					txd_ff <= tx_shift_ff[0];
					tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
					tx_bit_ff <= 3'h0;
				end
				UFX_TX_DATA: begin
					if (tx_bit_ff == tx_last_bit) begin
						tx_stop_ff <= 1'b0;
						if (cfg.par_en) begin
							tx_state_ff <= UFX_TX_PAR;
							txd_ff <= tx_par_ff;
						end else begin
							tx_state_ff <= UFX_TX_STOP;
							txd_ff <= 1'b1;
						end
					end else begin
						tx_bit_ff <= tx_bit_ff + 3'h1;
						txd_ff <= tx_shift_ff[0];
						tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
					end
				end
				UFX_TX_PAR: begin
					tx_state_ff <= UFX_TX_STOP;
					txd_ff <= 1'b1;
				end
				UFX_TX_STOP: begin
					if (tx_last_stop) begin
						tx_state_ff <= UFX_TX_IDLE;
					end else begin
						tx_stop_ff <= 1'b1;
					end
				end
				default: begin
					tx_state_ff <= UFX_TX_IDLE;
					txd_ff <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// Receive path
	// ****************************************
	ufx_rx_state_t rx_state_ff;
	logic rxd_meta_ff;
	logic rxd_s_ff;
	logic rx_phase_ff;
	logic [7:0] rx_shift_ff;
	logic [2:0] rx_bit_ff;
	logic rx_parbit_ff;
	logic rx_half;
	logic rx_samp;
	logic frame_done;
	logic [7:0] rx_char;
	logic pend_valid_ff;
	logic [7:0] pend_data_ff;
	logic rxf_in_ready;
	logic ovr_set;
	ufx_err_t err_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_meta_ff <= 1'b1;
			rxd_s_ff <= 1'b1;
		end else begin
			rxd_meta_ff <= rxd;
			rxd_s_ff <= rxd_meta_ff;
		end
	end

	// Half-bit ticks: odd ones land on bit centres
	assign rx_half = src_tick & rx_bs[17] & (rx_state_ff != UFX_RX_IDLE);
	assign rx_samp = rx_half & rx_phase_ff;
	assign frame_done = rx_samp & (rx_state_ff == UFX_RX_STOP);
	assign rx_char = cfg.char_length_sel ? {1'b0, rx_shift_ff[7:1]} : rx_shift_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_acc_ff <= 17'h00000;
		end else if (rx_state_ff == UFX_RX_IDLE) begin
			rx_acc_ff <= 17'h00000;
		end else if (src_tick) begin
			rx_acc_ff <= rx_bs[16:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_ff <= UFX_RX_IDLE;
			rx_phase_ff <= 1'b0;
			rx_shift_ff <= 8'h00;
			rx_bit_ff <= 3'h0;
			rx_parbit_ff <= 1'b0;
		end else begin
			if (rx_half) begin
				rx_phase_ff <= ~rx_phase_ff;
			end
			case (rx_state_ff)
				UFX_RX_IDLE: begin
					rx_phase_ff <= 1'b0;
					if (!rxd_s_ff) begin
						rx_state_ff <= UFX_RX_START;
					end
				end
				UFX_RX_START: begin
					if (rx_half) begin
						rx_phase_ff <= 1'b0;
						rx_bit_ff <= 3'h0;
						// A glitch shorter than half a bit is not a start
						rx_state_ff <= rxd_s_ff ? UFX_RX_IDLE : UFX_RX_DATA;
					end
				end
				UFX_RX_DATA: begin
					if (rx_samp) begin
						rx_shift_ff <= {rxd_s_ff, rx_shift_ff[7:1]};
						rx_bit_ff <= rx_bit_ff + 3'h1;
						if (rx_bit_ff == tx_last_bit) begin
							rx_state_ff <= cfg.par_en ? UFX_RX_PAR : UFX_RX_STOP;
						end
					end
				end
				UFX_RX_PAR: begin
					if (rx_samp) begin
						rx_parbit_ff <= rxd_s_ff;
						rx_state_ff <= UFX_RX_STOP;
					end
				end
				UFX_RX_STOP: begin
					if (rx_samp) begin
						rx_state_ff <= UFX_RX_IDLE;
					end
				end
				default: rx_state_ff <= UFX_RX_IDLE;
			endcase
		end
	end

	// With flow control, the holding stage stands in for the receive shifter while the queue is full
	assign ovr_set = frame_done & ((~cfg.flow_en & ~rxf_in_ready) |
		(pend_valid_ff & ~rxf_in_ready));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_valid_ff <= 1'b0;
			pend_data_ff <= 8'h00;
		end else if (frame_done && !ovr_set) begin
			pend_valid_ff <= 1'b1;
			pend_data_ff <= rx_char;
		end else if (rxf_in_ready) begin
			pend_valid_ff <= 1'b0;
		end
	end

	ufx_fifo #(.WIDTH(UFX_DATA_W), .DEPTH(DEPTH)) u_rxq (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(pend_valid_ff),
		.in_ready(rxf_in_ready),
		.in_data(pend_data_ff),
		.out_valid(rx_not_empty),
		.out_ready(rx_rd),
		.out_data(rx_byte)
	);

	// Set beats clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_ff <= '0;
		end else begin
			err_ff.missing_stop <= (err_ff.missing_stop & ~err_clr.missing_stop) |
				(frame_done & ~rxd_s_ff);
			err_ff.overrun <= (err_ff.overrun & ~err_clr.overrun) | ovr_set;
			err_ff.parity_err <= (err_ff.parity_err & ~err_clr.parity_err) |
				(frame_done & cfg.par_en & (rx_parbit_ff != par_bit(rx_char, cfg)));
		end
	end
	assign err_flags = err_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rts <= 1'b0;
		end else begin
			rts <= cfg.flow_en & ~rxf_in_ready;
		end
	end

	assign irq = (|({tx_empty, tx_not_full} & tx_mask)) |
		(|({err_ff, rx_not_empty} & rx_mask));
endmodule : ufx_top

`default_nettype wire

//--- tb/ufx_top_assertions.sv
// Port-level checks for the serial transceiver.
`timescale 1ns/1ps
`default_nettype none

// ********************
// Checker
// ********************
module ufx_top_checker import ufx_pkg::*; (
	input wire logic core_clk, // Clock
	input wire logic rst_b, // Reset
	input wire ufx_cfg_t cfg, // Setup
	input wire logic tx_wr, // Push
	input wire logic tx_not_full, // Room
	input wire logic tx_empty, // Idle
	input wire logic rx_rd, // Pop
	input wire logic rx_not_empty, // Data
	input wire ufx_err_t err_flags, // Errors
	input wire ufx_err_t err_clr, // Clears
	input wire logic [1:0] tx_mask, // Masks
	input wire logic [3:0] rx_mask, // Masks
	input wire logic irq, // Interrupt
	input wire logic txd, // Line out
	input wire logic cts, // Go
	input wire logic rts // Stop
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_IRQ: assert property (irq == ((|({tx_empty, tx_not_full} & tx_mask))
			|| (|({err_flags, rx_not_empty} & rx_mask))))
		else $error("irq differs from masked flags");
	AST_IDLE: assert property (tx_empty |-> txd)
		else $error("line low while idle");
	AST_START: assert property (tx_empty && tx_wr && !cfg.flow_en |-> ##[1:3] !txd)
		else $error("no start bit after push");
	AST_BITLEN: assert property ($fell(txd) |-> !txd[*8])
		else $error("low bit too short");
	AST_NE_STAYS: assert property (rx_not_empty && !rx_rd |=> rx_not_empty)
		else $error("receive data lost");
	AST_RTS_OFF: assert property (!cfg.flow_en |-> !rts)
		else $error("rts without flow control");
	AST_RTS_EMPTY: assert property (!rx_not_empty && !$past(rx_not_empty) |-> !rts)
		else $error("rts with empty queue");
	AST_OVR_STICKY: assert property (err_flags.overrun && !err_clr.overrun |=> err_flags.overrun)
		else $error("overrun flag dropped");
	AST_CTS_HOLD: assert property (cfg.flow_en && cts && $past(cts) && $past(cts, 2)
			&& $past(tx_empty, 2) |-> txd)
		else $error("start while cts high");

	cover property (rts);
	cover property (err_flags.overrun);
	cover property (err_flags.parity_err && irq);
endmodule : ufx_top_checker

bind ufx_top ufx_top_checker u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .tx_wr(tx_wr), .tx_not_full(tx_not_full),
	.tx_empty(tx_empty), .rx_rd(rx_rd), .rx_not_empty(rx_not_empty), .err_flags(err_flags), .err_clr(err_clr),
	.tx_mask(tx_mask), .rx_mask(rx_mask), .irq(irq), .txd(txd), .cts(cts), .rts(rts)
);
`default_nettype wire

//--- tb/ufx_remote.sv
// Remote serial device model on the line side.
`timescale 1ns/1ps
`default_nettype none

module ufx_remote #(
	parameter int BIT = 16
) (
	input wire logic core_clk, // Clock
	input wire logic txd, // From device
	output logic rxd, // To device
	input wire logic rts, // Pause request
	input wire logic [3:0] frame_len // Bits to capture
);
	logic [11:0] got;
	int n_got;
	int n_stall;
	logic heed_rts;

	initial begin
		rxd = 1'h1;
		n_got = 0;
		n_stall = 0;
		heed_rts = 1'h1;
	end

	// Capture from start edge, sampling at bit centres
	always begin
		@(negedge txd);
		got = 12'hFFF;
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < frame_len; i++) begin
			got[i] = txd;
			if (i + 1 < frame_len)
				repeat (BIT) @(posedge core_clk);
		end
		n_got++;
	end

	task automatic send(input logic [11:0] fr, input int len);
		// No new frame for up to 3000 cycles while the device asks for a pause
		for (int k = 0; k < 3000 && heed_rts && rts === 1'h1; k++)
			@(posedge core_clk);
		if (heed_rts && rts === 1'h1)
			n_stall++;
		for (int i = 0; i < len; i++) begin
			rxd <= fr[i];
			repeat (BIT) @(posedge core_clk);
		end
		rxd <= 1'h1;
		// One idle edge, so a following frame never reassigns rxd in this step
		@(posedge core_clk);
	endtask : send
endmodule : ufx_remote
`default_nettype wire

//--- tb/ufx_top_bench.sv
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ps
`default_nettype none

module ufx_top_bench import ufx_pkg::*;;
	typedef struct packed {
		logic c7;
		logic pe;
		logic [1:0] pm;
		logic two;
		logic [7:0] d;
		logic p;
		logic [1:0] src;
	} ufx_row_t;

	logic core_clk, rst_b, tx_wr, tx_not_full, tx_empty, rx_rd, rx_not_empty, irq, rxd, txd, cts, rts;
	ufx_cfg_t cfg;
	ufx_err_t err_flags, err_clr;
	logic [7:0] tx_byte, rx_byte;
	logic [1:0] tx_mask;
	logic [3:0] rx_mask, frame_len;
	int err_total, checks_done, n;
	ufx_row_t r;
	logic [11:0] f;
	// Parity worked by hand: 77 has six ones, 41 two
	ufx_row_t rows [6] = '{
		'{1'h0, 1'h0, UFX_PAR_EVEN, 1'h0, 8'hA5, 1'h0, UFX_SRC_26M},
		'{1'h0, 1'h1, UFX_PAR_EVEN, 1'h0, 8'h77, 1'h0, UFX_SRC_13M},
		'{1'h0, 1'h1, UFX_PAR_ODD, 1'h0, 8'h77, 1'h1, UFX_SRC_6M5},
		'{1'h0, 1'h1, UFX_PAR_SPACE, 1'h0, 8'hFF, 1'h0, UFX_SRC_3M25},
		'{1'h0, 1'h1, UFX_PAR_MARK, 1'h1, 8'h00, 1'h1, UFX_SRC_26M},
		'{1'h1, 1'h1, UFX_PAR_EVEN, 1'h1, 8'h41, 1'h0, UFX_SRC_13M}
	};

	ufx_top uut (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .tx_wr(tx_wr), .tx_byte(tx_byte),
		.tx_not_full(tx_not_full), .tx_empty(tx_empty), .rx_rd(rx_rd), .rx_byte(rx_byte),
		.rx_not_empty(rx_not_empty), .err_flags(err_flags), .err_clr(err_clr), .tx_mask(tx_mask),
		.rx_mask(rx_mask), .irq(irq), .rxd(rxd), .txd(txd), .cts(cts), .rts(rts));
	ufx_remote #(.BIT(16)) peer (.core_clk(core_clk), .txd(txd), .rxd(rxd), .rts(rts), .frame_len(frame_len));

	// Clock runs before any setup write
	always #5 core_clk = ~core_clk;

	// ********************
	// Helpers
	// ********************
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic push(input logic [7:0] b);
		@(posedge core_clk);
		tx_wr <= 1'h1;
		tx_byte <= b;
		tick(1);
		tx_wr <= 1'h0;
	endtask : push

	task automatic pop();
		@(posedge core_clk);
		rx_rd <= 1'h1;
		tick(1);
		rx_rd <= 1'h0;
	endtask : pop

	task automatic clr();
		@(posedge core_clk);
		err_clr <= 3'h7;
		tick(1);
		err_clr <= 3'h0;
		tick(1);
	endtask : clr

	task automatic drain();
		// Read until empty
		for (int i = 0; i < 8 && rx_not_empty === 1'h1; i++)
			pop();
	endtask : drain

	task automatic wait_rx();
		for (int i = 0; i < 2000 && rx_not_empty !== 1'h1; i++)
			tick(1);
		if (rx_not_empty !== 1'h1) begin
			err_total++;
			give_verdict();
		end
	endtask : wait_rx

	task automatic wait_tx(input int want);
		for (int i = 0; i < 2000 && peer.n_got != want; i++)
			tick(1);
		if (peer.n_got != want) begin
			err_total++;
			give_verdict();
		end
	endtask : wait_tx

	function automatic int flen(input ufx_row_t x);
		return 2 + (x.c7 ? 7 : 8) + x.pe + x.two;
	endfunction : flen

	function automatic logic [11:0] mk(input ufx_row_t x);
		mk = 12'hFFF;
		mk[0] = 1'h0;
		for (int i = 0; i < (x.c7 ? 7 : 8); i++)
			mk[1 + i] = x.d[i];
		if (x.pe)
			mk[x.c7 ? 8 : 9] = x.p;
	endfunction : mk

	task automatic setcfg(input ufx_row_t x, input logic fe);
		@(posedge core_clk);
		// Divisor halves as the source halves: a bit stays 16 core cycles
		cfg <= '{x.src, 16'h0080 >> x.src, x.c7, x.pe, x.pm, x.two, fe};
		frame_len <= 4'(flen(x));
		tick(1);
	endtask : setcfg

	// ********************
	// Sequence
	// ********************
	initial begin
		core_clk = 1'h0;
		rst_b = 1'h0;
		cfg = '0;
		tx_wr = 1'h0;
		tx_byte = 8'h00;
		rx_rd = 1'h0;
		err_clr = 3'h0;
		tx_mask = 2'h0;
		rx_mask = 4'h0;
		// High while flow control is off: must not block
		cts = 1'h1;
		frame_len = 4'hA;
		err_total = 0;
		checks_done = 0;
		repeat (4) @(posedge core_clk);
		chk("reset", {txd, rts, tx_not_full, tx_empty, rx_not_empty, err_flags}, 12'h0B0);
		rst_b <= 1'h1;
		foreach (rows[k]) begin
			setcfg(rows[k], 1'h0);
			f = mk(rows[k]);
			n = peer.n_got;
			push(rows[k].d);
			wait_tx(n + 1);
			chk("tx frame", peer.got, f);
			peer.send(f, flen(rows[k]));
			wait_rx();
			chk("rx byte", rx_byte, rows[k].c7 ? {1'h0, rows[k].d[6:0]} : rows[k].d);
			chk("rx errors", {tx_empty, err_flags}, 4'h8);
			pop();
		end
		setcfg(rows[2], 1'h0);
		f = mk(rows[2]);
		f[9] = ~f[9];
		peer.send(f, 11);
		tick(4);
		chk("parity flag", err_flags, 3'h1);
		rx_mask <= 4'h2;
		tick(1);
		chk("irq on", irq, 1'h1);
		clr();
		chk("irq off", {irq, err_flags}, 4'h0);
		drain();
		setcfg(rows[0], 1'h0);
		f = mk(rows[0]);
		f[9] = 1'h0;
		peer.send(f, 10);
		tick(4);
		chk("stop flag", err_flags, 3'h4);
		clr();
		drain();
		r = rows[0];
		for (int j = 0; j < 6; j++) begin
			r.d = 8'h10 + 8'(j);
			peer.send(mk(r), 10);
		end
		tick(4);
		chk("overrun flag", err_flags, 3'h2);
		rx_mask <= 4'h4;
		tick(1);
		chk("irq overrun", irq, 1'h1);
		for (int j = 0; j < 4; j++) begin
			chk("queued byte", rx_byte, 8'h10 + 8'(j));
			pop();
		end
		drain();
		chk("drained", rx_not_empty, 1'h0);
		clr();
		setcfg(rows[0], 1'h1);
		for (int j = 0; j < 4; j++) begin
			r.d = 8'h20 + 8'(j);
			peer.send(mk(r), 10);
		end
		tick(4);
		r.d = 8'h24;
		// Remote already committed to this frame: it must wait in the holding stage
		peer.heed_rts = 1'h0;
		fork
			peer.send(mk(r), 10);
		join_none
		tick(200);
		chk("rts holds", {rts, err_flags}, 4'h8);
		for (int j = 0; j < 5; j++) begin
			wait_rx();
			chk("flow byte", rx_byte, 8'h20 + 8'(j));
			pop();
		end
		chk("no overrun", err_flags, 3'h0);
		n = peer.n_got;
		for (int j = 0; j < 5; j++)
			push(8'h30 + 8'(j));
		chk("tx full", tx_not_full, 1'h0);
		tick(64);
		chk("cts blocks", {txd, peer.n_got == n}, 2'h3);
		cts <= 1'h0;
		for (int j = 0; j < 4; j++) begin
			wait_tx(n + j + 1);
			r.d = 8'h30 + 8'(j);
			chk("queued frame", peer.got, mk(r));
		end
		tick(60);
		chk("fifth refused", {tx_empty, peer.n_got == n + 4}, 2'h3);
		chk("remote stalls", 12'(peer.n_stall), 12'h000);
		give_verdict();
	end
endmodule : ufx_top_bench
`default_nettype wire
